/* hdl/lrm_top.sv */
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lrm_top #(
   parameter int NPEER    = 8,
   parameter int AGE_W    = 16,
   parameter int POWER_W  = 3,
   parameter int SEC_CYC  = lrm_pkg::SECOND_CYCLES
) (
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Interrupt
   output logic                          irq,
   // Received packet
   input  wire logic                     rx_valid,
   input  wire logic                     rx_generic,
   input  wire logic [$clog2(NPEER)-1:0] rx_peer,
   input  wire logic [3:0]               rx_hint,
   input  wire logic [3:0]               rx_scheme,
   // Received keep-alive
   input  wire logic                     rx_ka_valid,
   input  wire logic                     rx_ka_request,
   input  wire logic [2:0]               keepalive_tx_count,
   input  wire logic [7:0]               rx_snr,
   input  wire logic [7:0]               rx_power,
   input  wire logic [2:0]               downlink_repeat_count,
   input  wire logic [2:0]               uplink_repeat_count,
   // Transmit request
   input  wire logic                     tx_req,
   input  wire logic                     tx_control,
   input  wire logic [$clog2(NPEER)-1:0] tx_peer,
   output logic                          tx_grant,
   output logic [3:0]                    tx_scheme,
   output logic [3:0]                    link_quality_hint,
   // Keep-alive link
   input  wire logic                     ka_ack,
   input  wire logic                     ka_nack,
   output logic                          ka_tx,
   output logic [3:0]                    ka_tx_scheme,
   output logic [POWER_W-1:0]            ka_tx_power,
   output logic [2:0]                    ka_tx_count,
   output logic [$clog2(NPEER)-1:0]      ka_peer,
   output logic                          ack_send,
   output logic [3:0]                    ack_scheme,
   // Keep-alive reports
   output logic [7:0]                    rx_snr_report,
   output logic [7:0]                    rx_power_report,
   output logic [3:0]                    rx_scheme_report
);

   localparam int PW  = $clog2(NPEER);
   localparam int CW  = $clog2(SEC_CYC + 1);

   // ==========================================
   // State
   typedef struct packed {
      logic                       fixed_en;
      logic [3:0]                 fixed_scheme;
      logic [3:0]                 ctl_scheme;
      logic                       terminal;
      logic                       root;
      logic [2:0]                 retry;
      logic [AGE_W-1:0]           timeout;
      logic [lrm_pkg::ST_W-1:0]   status;
      logic [lrm_pkg::ST_W-1:0]   mask;
      logic [PW-1:0]              peer_sel;
      logic [PW-1:0]              ka_peer;
      logic [NPEER-1:0][3:0]      sch;
      logic [NPEER-1:0][AGE_W-1:0] age;
      logic [NPEER-1:0]           sent;
      logic [CW-1:0]              presc;
      logic [31:0]                rdata;
      logic                       tx_grant;
      logic [3:0]                 tx_scheme;
      logic [3:0]                 tx_hint;
      logic [3:0]                 own_hint;
      logic                       ack_send;
      logic [3:0]                 ack_scheme;
      logic [7:0]                 rep_snr;
      logic [7:0]                 rep_pow;
      logic [3:0]                 rep_enc;
      logic                       ka_start;
      logic [3:0]                 ka_start_scheme;
      logic                       relax;
   } lrm_top_s;

   lrm_top_s st_reg;
   lrm_top_s st_next;

   // ==========================================
   // Keep-alive engine
   logic               ka_busy;
   logic [3:0]         ka_scheme;
   logic [POWER_W-1:0] ka_power;
   logic [2:0]         ka_count;
   logic               ka_done;
   logic               ka_fail;
   logic               ka_txp;

   lrm_ka_engine #(
      .POWER_W (POWER_W)
   ) u_ka (
      .pclk         (pclk),
      .presetn      (presetn),
      .start        (st_reg.ka_start),
      .start_scheme (st_reg.ka_start_scheme),
      .relax        (st_reg.relax),
      .retry_limit  (st_reg.retry),
      .ack          (ka_ack),
      .nack         (ka_nack),
      .busy         (ka_busy),
      .tx           (ka_txp),
      .scheme       (ka_scheme),
      .power        (ka_power),
      .count        (ka_count),
      .done         (ka_done),
      .fail         (ka_fail)
   );

   // ==========================================
   // Bus decode
   logic        acc;
   logic        wr;
   logic        hit;
   logic [31:0] rmux;
   logic        tick;
   logic [lrm_pkg::ST_W-1:0] ev;

   always_comb begin
      acc = psel && penable;
      wr  = acc && pwrite;
      hit = 1'b1;
      case (paddr)
         lrm_pkg::OFS_CTRL: begin
            rmux = {13'h0000, st_reg.retry, 2'h0, st_reg.root, st_reg.terminal,
                    st_reg.ctl_scheme, st_reg.fixed_scheme, 3'h0, st_reg.fixed_en};
         end
         lrm_pkg::OFS_TIMEOUT: begin
            rmux = 32'(st_reg.timeout);
         end
         lrm_pkg::OFS_STATUS: begin
            rmux = 32'(st_reg.status);
         end
         lrm_pkg::OFS_MASK: begin
            rmux = 32'(st_reg.mask);
         end
         lrm_pkg::OFS_KA_CMD: begin
            rmux = 32'(st_reg.ka_peer) << lrm_pkg::KA_CMD_PEER_LSB;
         end
         lrm_pkg::OFS_KA_STAT: begin
            rmux = {18'h00000, 3'(ka_power), ka_count, ka_scheme, 3'h0, ka_busy};
         end
         lrm_pkg::OFS_REPORT: begin
            rmux = {12'h000, st_reg.rep_enc, st_reg.rep_pow, st_reg.rep_snr};
         end
         lrm_pkg::OFS_PEER_SEL: begin
            rmux = 32'(st_reg.peer_sel);
         end
         lrm_pkg::OFS_PEER_DATA: begin
            rmux = {st_reg.sent[st_reg.peer_sel], 11'h000,
                    st_reg.sch[st_reg.peer_sel], 16'(st_reg.age[st_reg.peer_sel])};
         end
         default: begin
            rmux = 32'h0000_0000;
            hit  = 1'b0;
         end
      endcase
   end

   // ==========================================
   // Next state
   always_comb begin
      st_next          = st_reg;
      st_next.tx_grant = 1'b0;
      st_next.ack_send = 1'b0;
      st_next.ka_start = 1'b0;
      st_next.relax    = 1'b0;
      ev               = '0;
      tick             = (st_reg.presc == CW'(SEC_CYC - 1));

      // One-second prescaler
      st_next.presc = tick ? '0 : st_reg.presc + 1'b1;

      // Read data captured in the setup phase
      if (psel && !penable) begin
         st_next.rdata = rmux;
      end

      // Register writes
      if (wr) begin
         case (paddr)
            lrm_pkg::OFS_CTRL: begin
               st_next.fixed_en     = pwdata[lrm_pkg::CTRL_FIXED_EN];
               st_next.fixed_scheme = pwdata[lrm_pkg::CTRL_FIXED_LSB +: 4];
               st_next.ctl_scheme   = pwdata[lrm_pkg::CTRL_CTLSCH_LSB +: 4];
               st_next.terminal     = pwdata[lrm_pkg::CTRL_TERMINAL];
               st_next.root         = pwdata[lrm_pkg::CTRL_ROOT];
               st_next.retry        = pwdata[lrm_pkg::CTRL_RETRY_LSB +: 3];
            end
            lrm_pkg::OFS_TIMEOUT: begin
               st_next.timeout = pwdata[AGE_W-1:0];
            end
            lrm_pkg::OFS_MASK: begin
               st_next.mask = pwdata[lrm_pkg::ST_W-1:0];
            end
            lrm_pkg::OFS_KA_CMD: begin
               if (!ka_busy) begin
                  st_next.ka_peer = pwdata[lrm_pkg::KA_CMD_PEER_LSB +: PW];
               end
               st_next.ka_start = pwdata[lrm_pkg::KA_CMD_START];
               st_next.ka_start_scheme = st_reg.sch[pwdata[lrm_pkg::KA_CMD_PEER_LSB +: PW]];
               st_next.relax = pwdata[lrm_pkg::KA_CMD_RELAX];
            end
            lrm_pkg::OFS_PEER_SEL: begin
               st_next.peer_sel = pwdata[PW-1:0];
            end
            default: begin
               st_next.peer_sel = st_reg.peer_sel;
            end
         endcase
      end

      // Peer info ageing, saturating, in seconds
      for (int i = 0; i < NPEER; i++) begin
         if (tick && st_reg.age[i] != {AGE_W{1'b1}}) begin
            st_next.age[i] = st_reg.age[i] + 1'b1;
         end
      end

      // Exhausted retries record the most robust scheme for the link
      if (ka_fail) begin
         st_next.sch[st_reg.ka_peer] = lrm_pkg::S_R_DBPSK;
         st_next.age[st_reg.ka_peer] = '0;
         ev[lrm_pkg::ST_KA_FAIL] = 1'b1;
      end
      if (ka_done) begin
         ev[lrm_pkg::ST_KA_DONE] = 1'b1;
      end

      // Generic packet received: store hint and restart age
      if (rx_valid && rx_generic) begin
         st_next.sch[rx_peer] = rx_hint;
         st_next.age[rx_peer] = '0;
         st_next.own_hint = rx_scheme;
         ev[lrm_pkg::ST_RX_UPD] = 1'b1;
      end

      // Keep-alive received
      if (rx_ka_valid) begin
         st_next.rep_snr  = rx_snr;
         st_next.rep_pow  = rx_power;
         st_next.rep_enc  = rx_scheme;
         st_next.own_hint = rx_scheme;
         st_next.ack_send = 1'b1;
         if (keepalive_tx_count > 3'h1) begin
            st_next.ack_scheme = lrm_pkg::scheme_max(rx_scheme,
                                                     lrm_pkg::S_DBPSK_CC);
         end else begin
            st_next.ack_scheme = lrm_pkg::S_DBPSK_CC;
         end
         if (rx_ka_request && st_reg.terminal && !ka_busy) begin
            st_next.ka_start        = 1'b1;
            st_next.ka_peer         = rx_peer;
            st_next.ka_start_scheme = lrm_pkg::S_DBPSK_CC;
         end
         if (st_reg.root && (downlink_repeat_count == lrm_pkg::REP_EXHAUSTED ||
                             uplink_repeat_count == lrm_pkg::REP_EXHAUSTED)) begin
            ev[lrm_pkg::ST_ALV_FAIL] = 1'b1;
         end
      end

      // Transmit scheme selection
      if (tx_req) begin
         st_next.tx_grant = 1'b1;
         st_next.tx_hint  = st_reg.own_hint;
         if (tx_control) begin
            st_next.tx_scheme = st_reg.ctl_scheme;
         end else if (st_reg.fixed_en) begin
            st_next.tx_scheme = st_reg.fixed_scheme;
         end else if (!st_reg.sent[tx_peer]) begin
            st_next.tx_scheme = lrm_pkg::S_R_DBPSK;
         end else if (st_reg.age[tx_peer] >= st_reg.timeout) begin
            st_next.tx_scheme = lrm_pkg::S_R_DBPSK;
         end else if (st_reg.sch[tx_peer] == lrm_pkg::S_NONE) begin
            st_next.tx_scheme = lrm_pkg::S_R_DBPSK;
         end else begin
            st_next.tx_scheme = st_reg.sch[tx_peer];
         end
         if (!tx_control) begin
            st_next.sent[tx_peer] = 1'b1;
         end
      end

      // Sticky status, set wins over write-one-to-clear
      if (wr && paddr == lrm_pkg::OFS_STATUS) begin
         st_next.status = (st_reg.status & ~pwdata[lrm_pkg::ST_W-1:0]) | ev;
      end else begin
         st_next.status = st_reg.status | ev;
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg              <= '0;
         st_reg.fixed_en     <= lrm_pkg::CTRL_RST[lrm_pkg::CTRL_FIXED_EN];
         st_reg.fixed_scheme <= lrm_pkg::CTRL_RST[lrm_pkg::CTRL_FIXED_LSB +: 4];
         st_reg.ctl_scheme   <= lrm_pkg::CTRL_RST[lrm_pkg::CTRL_CTLSCH_LSB +: 4];
         st_reg.retry        <= lrm_pkg::CTRL_RST[lrm_pkg::CTRL_RETRY_LSB +: 3];
         st_reg.timeout      <= lrm_pkg::TIMEOUT_RST[AGE_W-1:0];
         st_reg.sch          <= {NPEER{lrm_pkg::S_NONE}};
         st_reg.own_hint     <= lrm_pkg::S_NONE;
         st_reg.tx_hint      <= lrm_pkg::S_NONE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================
   // Outputs
   assign pready            = 1'b1;
   assign pslverr           = acc && !hit;
   assign prdata            = st_reg.rdata;
   assign irq               = |(st_reg.status & st_reg.mask);
   assign tx_grant          = st_reg.tx_grant;
   assign tx_scheme         = st_reg.tx_scheme;
   assign link_quality_hint = st_reg.tx_hint;
   assign ka_tx             = ka_txp;
   assign ka_tx_scheme      = ka_scheme;
   assign ka_tx_power       = ka_power;
   assign ka_tx_count       = ka_count;
   assign ka_peer           = st_reg.ka_peer;
   assign ack_send          = st_reg.ack_send;
   assign ack_scheme        = st_reg.ack_scheme;
   assign rx_snr_report     = st_reg.rep_snr;
   assign rx_power_report   = st_reg.rep_pow;
   assign rx_scheme_report  = st_reg.rep_enc;

endmodule
`default_nettype wire

/* hdl/lrm_pkg.sv */
// Contract
// - Data scheme is one of eight modulations
// - Only generic data uses adaptive selection
// - Scheme decided locally from neighbour hints
// - Root may impose fixed mode at registration
// - Every generic packet carries four-bit hint
// - Received hint stored, peer age cleared
// - Age at or above timeout forces robust
// - First data to a peer is robust
// - Fresh hint used unless it is 0xF
// - Keep-alive retry: same first, then escalate
// - Retries exhausted store most robust scheme
// - Ack at least as robust when count>1
// - Keep-alive uses CC, RDQPSK, RDBPSK only
// - Terminal answers request with own response
// - Keep-alive reports last rx SNR, power, scheme
// - Escalate power first, then modulation
// - Relax modulation first, then power
// - Repeat count of 7 fails root procedure
package lrm_pkg;

   // ==========================================
   // Register map
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_TIMEOUT   = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_MASK      = 8'h0C;
   localparam logic [7:0] OFS_KA_CMD    = 8'h10;
   localparam logic [7:0] OFS_KA_STAT   = 8'h14;
   localparam logic [7:0] OFS_REPORT    = 8'h18;
   localparam logic [7:0] OFS_PEER_SEL  = 8'h1C;
   localparam logic [7:0] OFS_PEER_DATA = 8'h20;

   // ==========================================
   // Fields and reset values
   localparam int CTRL_FIXED_EN   = 0;
   localparam int CTRL_FIXED_LSB  = 4;
   localparam int CTRL_CTLSCH_LSB = 8;
   localparam int CTRL_TERMINAL   = 12;
   localparam int CTRL_ROOT       = 13;
   localparam int CTRL_RETRY_LSB  = 16;
   localparam int KA_CMD_START    = 0;
   localparam int KA_CMD_RELAX    = 1;
   localparam int KA_CMD_PEER_LSB = 8;
   localparam logic [31:0] CTRL_RST    = 32'h0003_0700;
   localparam logic [31:0] TIMEOUT_RST = 32'h0000_003C;
   localparam int ST_KA_DONE  = 0;
   localparam int ST_KA_FAIL  = 1;
   localparam int ST_ALV_FAIL = 2;
   localparam int ST_RX_UPD   = 3;
   localparam int ST_W        = 4;
   localparam logic [2:0] REP_EXHAUSTED = 3'h7;

   // ==========================================
   // Timing
   localparam int SECOND_NS     = 1000000000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

   // ==========================================
   // Scheme codes, higher code is more robust
   typedef enum logic [3:0] {
      S_D8PSK    = 4'b0000,
      S_D8PSK_CC = 4'b0001,
      S_DQPSK    = 4'b0010,
      S_DQPSK_CC = 4'b0011,
      S_DBPSK    = 4'b0100,
      S_DBPSK_CC = 4'b0101,
      S_R_DQPSK  = 4'b0110,
      S_R_DBPSK  = 4'b0111,
      S_NONE     = 4'b1111
   } lrm_scheme_e;

   function automatic logic [3:0] scheme_max(input logic [3:0] a, input logic [3:0] b);
      logic [3:0] x;
      x = (a > b) ? a : b;
      if (x > S_R_DBPSK) begin
         x = S_R_DBPSK;
      end
      return x;
   endfunction

endpackage

/* hdl/lrm_ka_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module lrm_ka_engine #(
   parameter int POWER_W = 3
) (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // Control
   input  wire logic               start,
   input  wire logic [3:0]         start_scheme,
   input  wire logic               relax,
   input  wire logic [2:0]         retry_limit,
   input  wire logic               ack,
   input  wire logic               nack,
   // Status
   output logic                    busy,
   output logic                    tx,
   output logic [3:0]              scheme,
   output logic [POWER_W-1:0]      power,
   output logic [2:0]              count,
   output logic                    done,
   output logic                    fail
);

   // ==========================================
   // State
   typedef struct packed {
      logic               busy;
      logic               tx;
      logic [3:0]         scheme;
      logic [POWER_W-1:0] power;
      logic [2:0]         count;
      logic               done;
      logic               fail;
   } lrm_ka_s;

   lrm_ka_s st_reg;
   lrm_ka_s st_next;

   // ==========================================
   // Retry and escalation
   always_comb begin
      st_next      = st_reg;
      st_next.tx   = 1'b0;
      st_next.done = 1'b0;
      st_next.fail = 1'b0;
      if (!st_reg.busy && start) begin
         st_next.busy   = 1'b1;
         st_next.scheme = lrm_pkg::scheme_max(start_scheme, lrm_pkg::S_DBPSK_CC);
         st_next.count  = 3'h1;
         st_next.tx     = 1'b1;
      end else if (st_reg.busy && ack) begin
         st_next.busy = 1'b0;
         st_next.done = 1'b1;
      end else if (st_reg.busy && nack) begin
         if (st_reg.count >= retry_limit) begin
            st_next.busy = 1'b0;
            st_next.fail = 1'b1;
         end else begin
            if (st_reg.count >= 3'h2) begin
               if (st_reg.power != {POWER_W{1'b1}}) begin
                  st_next.power = st_reg.power + 1'b1;
               end else begin
                  st_next.scheme = lrm_pkg::scheme_max(st_reg.scheme + 4'h1,
                                                       st_reg.scheme);
               end
            end
            st_next.count = st_reg.count + 3'h1;
            st_next.tx    = 1'b1;
         end
      end else if (!st_reg.busy && relax) begin
         if (st_reg.scheme > lrm_pkg::S_DBPSK_CC) begin
            st_next.scheme = st_reg.scheme - 4'h1;
         end else if (st_reg.power != '0) begin
            st_next.power = st_reg.power - 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '{busy: 1'b0, tx: 1'b0, scheme: lrm_pkg::S_DBPSK_CC,
                     power: '0, count: 3'h0, done: 1'b0, fail: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign busy   = st_reg.busy;
   assign tx     = st_reg.tx;
   assign scheme = st_reg.scheme;
   assign power  = st_reg.power;
   assign count  = st_reg.count;
   assign done   = st_reg.done;
   assign fail   = st_reg.fail;

endmodule
`default_nettype wire

/* bench/lrm_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far-side node: answers each keep-alive attempt
module lrm_peer (
   // Clock, reset and attempt
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ka_tx,
   input  wire logic [2:0] ka_tx_count,
   input  wire logic [2:0] nack_n,
   // Answer
   output logic            ka_ack,
   output logic            ka_nack
);
   // Attempts numbered up to nack_n are answered with nack, later ones acknowledged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ka_ack  <= 1'b0;
         ka_nack <= 1'b0;
      end else begin
         ka_ack  <= ka_tx && (ka_tx_count > nack_n);
         ka_nack <= ka_tx && (ka_tx_count <= nack_n);
      end
   end
endmodule
`default_nettype wire

/* bench/lrm_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker
module lrm_checker #(
   parameter int POWER_W = 3
) (
   // Watched ports
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               tx_req,
   input wire logic               tx_grant,
   input wire logic               rx_ka_valid,
   input wire logic [2:0]         keepalive_tx_count,
   input wire logic [3:0]         rx_scheme,
   input wire logic [7:0]         rx_snr,
   input wire logic               ack_send,
   input wire logic [3:0]         ack_scheme,
   input wire logic [7:0]         rx_snr_report,
   input wire logic [3:0]         rx_scheme_report,
   input wire logic               ka_tx,
   input wire logic               ka_nack,
   input wire logic [3:0]         ka_tx_scheme,
   input wire logic [POWER_W-1:0] ka_tx_power,
   input wire logic [2:0]         ka_tx_count
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_grant;
      tx_req |=> tx_grant;
   endproperty
   a_grant: assert property (p_grant) else $error("grant missing");
   property p_nogrant;
      !tx_req |=> !tx_grant;
   endproperty
   a_nogrant: assert property (p_nogrant) else $error("grant unasked");
   property p_ka_set;
      ka_tx |-> ka_tx_scheme inside {4'h5, 4'h6, 4'h7};
   endproperty
   a_ka_set: assert property (p_ka_set) else $error("bad keep-alive scheme");
   property p_ack_lo;
      rx_ka_valid && keepalive_tx_count <= 3'h1 |=> ack_send && ack_scheme == 4'h5;
   endproperty
   a_ack_lo: assert property (p_ack_lo) else $error("bad plain ack");
   property p_ack_hi;
      rx_ka_valid && keepalive_tx_count > 3'h1 |=> ack_send && ack_scheme <= 4'h7
         && ack_scheme >= 4'h5 && ack_scheme >= $past(rx_scheme);
   endproperty
   a_ack_hi: assert property (p_ack_hi) else $error("ack too weak");
   property p_retry1;
      ka_nack && ka_tx_count == 3'h1 |=> ka_tx && ka_tx_count == 3'h2 && $stable(ka_tx_scheme);
   endproperty
   a_retry1: assert property (p_retry1) else $error("first retry changed");
   property p_power;
      ka_nack && ka_tx_count == 3'h2 && ka_tx_power != '1 |=> ka_tx
         && ka_tx_power == $past(ka_tx_power) + 1'b1 && $stable(ka_tx_scheme);
   endproperty
   a_power: assert property (p_power) else $error("power not raised first");
   property p_report;
      rx_ka_valid |=> rx_snr_report == $past(rx_snr) && rx_scheme_report == $past(rx_scheme);
   endproperty
   a_report: assert property (p_report) else $error("report stale");
endmodule
`default_nettype wire
bind lrm_top lrm_checker #(.POWER_W(POWER_W)) chk_u (.*);

/* bench/link_robustness_manager_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench
module link_robustness_manager_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0]  paddr, rx_snr, rx_power, rx_snr_report, rx_power_report;
   logic [31:0] pwdata, prdata, rd;
   logic        rx_valid, rx_generic, rx_ka_valid, rx_ka_request, tx_req, tx_control;
   logic [2:0]  rx_peer, tx_peer, ka_peer, keepalive_tx_count, downlink_repeat_count;
   logic [2:0]  uplink_repeat_count, ka_tx_power, ka_tx_count, nack_n;
   logic [3:0]  rx_hint, rx_scheme, tx_scheme, link_quality_hint, ka_tx_scheme, ack_scheme;
   logic [3:0]  rx_scheme_report;
   logic        ka_ack, ka_nack, ka_tx, ack_send, tx_grant;
   int          n_mismatch, tests_run;
   lrm_top #(.SEC_CYC(16)) dut_u (.*);
   lrm_peer peer_u (.pclk(pclk), .presetn(presetn), .ka_tx(ka_tx), .ka_tx_count(ka_tx_count),
                    .nack_n(nack_n), .ka_ack(ka_ack), .ka_nack(ka_nack));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 20) begin
         chk(pready, 1'b1);
         end_of_test;
      end
   endtask
   task automatic wst(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h08, 32'h0);
         n++;
      end while (rd[b] !== 1'b1 && n < 40);
      chk(rd[b], 1'b1);
      if (rd[b] !== 1'b1) end_of_test;
   endtask
   task automatic tx(input logic c, input logic [2:0] p, input logic [3:0] e);
      @(posedge pclk);
      {tx_req, tx_control, tx_peer} <= {1'b1, c, p};
      @(posedge pclk);
      tx_req <= 1'b0;
      @(negedge pclk);
      chk(tx_grant, 1'b1);
      chk(tx_scheme, e);
   endtask
   task automatic rx(input logic [2:0] p, input logic [3:0] h);
      @(posedge pclk);
      {rx_valid, rx_peer, rx_hint} <= {1'b1, p, h};
      @(posedge pclk);
      {rx_valid, rx_hint} <= {1'b0, ~h};
   endtask
   task automatic rxka(input logic [2:0] c, input logic [3:0] s, input logic [2:0] r,
                       input logic [3:0] e);
      @(posedge pclk);
      {rx_ka_valid, keepalive_tx_count, rx_scheme, downlink_repeat_count} <= {1'b1, c, s, r};
      @(posedge pclk);
      {rx_ka_valid, rx_scheme} <= {1'b0, ~s};
      @(negedge pclk);
      chk(ack_send, 1'b1);
      chk(ack_scheme, e);
      chk(rx_snr_report, 8'h5A);
      chk(rx_power_report, 8'hC3);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, rx_valid, rx_peer, rx_hint} = '0;
      {rx_scheme, rx_ka_valid, keepalive_tx_count, rx_power, downlink_repeat_count} = '0;
      {uplink_repeat_count, tx_req, tx_control, tx_peer, nack_n} = '0;
      {rx_generic, rx_ka_request, rx_snr, rx_power} = {2'b11, 8'h5A, 8'hC3};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0); chk(rd, lrm_pkg::CTRL_RST);
      apb(1'b0, 8'h04, 32'h0); chk(rd, lrm_pkg::TIMEOUT_RST);
      apb(1'b1, 8'h40, 32'h1); chk(err, 1'b1);
      tx(1'b0, 3'h1, 4'h7);
      rx(3'h1, 4'h2); tx(1'b0, 3'h1, 4'h2);
      rx(3'h1, 4'hF); tx(1'b0, 3'h1, 4'h7);
      tx(1'b1, 3'h1, 4'h7);
      apb(1'b1, 8'h04, 32'h2); rx(3'h1, 4'h3); tx(1'b0, 3'h1, 4'h3);
      repeat (40) @(posedge pclk);
      tx(1'b0, 3'h1, 4'h7);
      apb(1'b1, 8'h00, 32'h0003_0711); tx(1'b0, 3'h1, 4'h1);
      apb(1'b1, 8'h00, lrm_pkg::CTRL_RST);
      tx(1'b0, 3'h2, 4'h7);
      for (int i = 0; i < 8; i++) begin
         rx(3'h2, 4'(i)); tx(1'b0, 3'h2, 4'(i));
      end
      apb(1'b1, 8'h10, 32'h101); wst(0);
      @(negedge pclk); chk(irq, 1'b0);
      apb(1'b1, 8'h0C, 32'hF); repeat (2) @(negedge pclk); chk(irq, 1'b1);
      apb(1'b1, 8'h08, 32'hF); repeat (2) @(negedge pclk); chk(irq, 1'b0);
      rx(3'h1, 4'h2); nack_n <= 3'h7;
      apb(1'b1, 8'h10, 32'h101); wst(1); tx(1'b0, 3'h1, 4'h7);
      nack_n <= 3'h0;
      rxka(3'h1, 4'h6, 3'h0, 4'h5);
      rxka(3'h2, 4'h6, 3'h0, 4'h6);
      rxka(3'h3, 4'h2, 3'h0, 4'h5);
      tx(1'b0, 3'h1, 4'h7); chk(link_quality_hint, 4'h2);
      apb(1'b1, 8'h00, 32'h0003_1700); rxka(3'h1, 4'h5, 3'h0, 4'h5); wst(0);
      apb(1'b1, 8'h00, 32'h0003_2700); rxka(3'h1, 4'h5, 3'h7, 4'h5); wst(2);
      apb(1'b1, 8'h10, 32'h102); apb(1'b0, 8'h14, 32'h0); chk(rd, 32'h0000_0150);
      end_of_test;
   end
endmodule
`default_nettype wire
